/* dv/scd_line_model.sv */
// line-side receiver model: detect pin follows carrier after LAT clocks
// assumes the bench says when carrier is on the medium
module scd_line_model
#(
  parameter int LAT = 1  // receiver latency in clocks
)
(
  input  wire logic sys_clk_i,
  input  wire logic carrier_i,
  output logic      detect_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [LAT:0] pipe_q = '0;  // carrier history
  // receiver reports carrier only after its own latency
  always @(posedge sys_clk_i)
    pipe_q <= {pipe_q[LAT-1:0], carrier_i};
  assign detect_pin_o = pipe_q[LAT-1];
endmodule

/* dv/scd_top_bench.sv */
// self-checking bench of the scrambler detect control block
// assumes scd_top with short transmitter-off counts and the line model
module scd_top_bench
  import scd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] REV = 5'h0C;  // arbitrary revision value
  logic        clk = 1'b0, rst_n = 1'b0, strap = 1'b0;
  logic        carrier = 1'b0, quiet = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        det, sp, en, lpbk, txoff, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          n_mismatch = 0, tests_run = 0, c;
  // 100 MHz clock
  always #5 clk = ~clk;
  scd_top #(.TX30_CYC(30), .TX50_CYC(50), .REV_ID(REV)) u_dut (
    .sys_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scramble_strap_pin_i(strap), .detect_input_pin_i(det),
    .tx_quiet_i(quiet), .lsm_info_i(10'h2A5),
    .scrambler_en_o(en), .scrambler_loopback_bit_o(lpbk),
    .signal_present_o(sp), .transmitter_off_output_o(txoff),
    .irq_o(irq));
  scd_line_model u_line (.sys_clk_i(clk), .carrier_i(carrier),
    .detect_pin_o(det));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus write: flags sampled mid-cycle, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    bit ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!tb);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  // bus read with data and response compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    bit ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    while (!tr);
    rready <= 1'b0;
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  // drive carrier or quiet, count cycles until the output follows
  task automatic go(input bit q, input logic lv, input int mx);
    @(posedge clk);
    if (q) quiet <= lv;
    else carrier <= lv;
    c = 0;
    while (((q ? txoff : sp) !== lv) && c < mx)
    begin
      @(negedge clk);
      c++;
    end
  endtask
  // reset held for ten clocks
  task automatic rst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // reset values, status, unmapped and read-only places
  task automatic t_regs();
    rd(8'h28, 32'h0, RESP_OKAY);
    rd(8'h40, {16'h0, REV, 1'b1, 10'h2A5}, RESP_OKAY);
    wr(8'h40, 16'h0000, RESP_OKAY);
    rd(8'h40, {16'h0, REV, 1'b1, 10'h2A5}, RESP_OKAY);
    rd(8'h04, 32'h0, RESP_SLVERR);
    wr(8'h28, 16'h3F03, RESP_OKAY);
    rd(8'h28, 32'h3F03, RESP_OKAY);
    chk("loopback", 1, lpbk);
    chk("enable", 1, en);
    wr(8'h28, 16'h0000, RESP_OKAY);
    chk("enable", 0, en);
    chk("loopback", 0, lpbk);
    $display("test regs done");
  endtask
  // strap at reset and while software clears the bit
  task automatic t_strap();
    strap <= 1'b1;
    rst();
    repeat (3) @(posedge clk);
    rd(8'h28, 32'h1, RESP_OKAY);
    wr(8'h28, 16'h0000, RESP_OKAY);
    rd(8'h28, 32'h1, RESP_OKAY);
    chk("enable", 1, en);
    strap <= 1'b0;
    repeat (4) @(posedge clk);
    wr(8'h28, 16'h0000, RESP_OKAY);
    rd(8'h28, 32'h0, RESP_OKAY);
    $display("test strap done");
  endtask
  // signal-present pass-through and every delay selection
  task automatic t_detect();
    int on[4] = '{ON0_CYC, ON1_CYC, ON2_CYC, ON3_CYC};
    int off[4] = '{OFF0_CYC, OFF1_CYC, OFF2_CYC, OFF3_CYC};
    wr(8'h28, 16'h0001, RESP_OKAY);
    go(0, 1, 100);
    chk("direct on", 1, c <= 8);
    go(0, 0, 100);
    chk("direct off", 1, c <= 8);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h28, 16'h00C1 | (16'(i) << 10) | (16'(i) << 12), RESP_OKAY);
      go(0, 1, 2000);
      chk("on delay", 1, c >= on[i] && c <= on[i] + 8);
      go(0, 0, 2000);
      chk("off delay", 1, c >= off[i] && c <= off[i] + 8);
    end
    $display("test detect done");
  endtask
  // transmitter-off for every selection
  task automatic t_txoff();
    int lo[4] = '{0, 30, 50, 100};
    int hi[4] = '{3, 36, 56, 100};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h28, 16'h0001 | (16'(i) << 8), RESP_OKAY);
      go(1, 1, 100);
      chk("tx delay", 1, c >= lo[i] && c <= hi[i]);
      go(1, 0, 5);
      chk("tx drop", 0, txoff);
    end
    $display("test txoff done");
  endtask
  // sticky events, masking and clear on read
  task automatic t_irq();
    rd(8'h44, 32'h7, RESP_OKAY);
    rd(8'h44, 32'h0, RESP_OKAY);
    wr(8'h28, 16'h0001, RESP_OKAY);
    go(0, 1, 100);
    chk("irq masked", 0, irq);
    rd(8'h44, 32'h1, RESP_OKAY);
    wr(8'h48, 16'h0001, RESP_OKAY);
    go(0, 0, 100);
    repeat (3) @(posedge clk);
    chk("irq fall masked", 0, irq);
    go(0, 1, 100);
    repeat (3) @(posedge clk);
    chk("irq raised", 1, irq);
    rd(8'h44, 32'h3, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq cleared", 0, irq);
    $display("test irq done");
  endtask
  // counts and verdict
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rst();
    t_regs();
    t_strap();
    t_detect();
    t_txoff();
    t_irq();
    stop_test();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule

/* dv/scd_top_chk.sv */
// port checker of the scrambler detect control top
// assumes it is bound to scd_top and sees its ports only
module scd_top_chk
  import scd_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        scramble_strap_pin_i,
  input wire logic        detect_input_pin_i,
  input wire logic        tx_quiet_i,
  input wire logic        scrambler_en_o,
  input wire logic        scrambler_loopback_bit_o,
  input wire logic        signal_present_o,
  input wire logic        transmitter_off_output_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain, reset disables every check
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_STRAP_FORCE: assert property
    (scramble_strap_pin_i [*5] |-> scrambler_en_o)
    else $error("enable not forced by strap");
  AST_TXOFF_DROP: assert property
    ((!tx_quiet_i || !scrambler_en_o) |=> !transmitter_off_output_o)
    else $error("transmitter off held without quiet");
  AST_TXOFF_CAUSE: assert property
    ($rose(transmitter_off_output_o) |->
     $past(tx_quiet_i) && $past(scrambler_en_o))
    else $error("transmitter off rose without quiet");
  AST_SP_RISE: assert property
    ($rose(signal_present_o) |-> $past(detect_input_pin_i, 3))
    else $error("signal present rose without detect");
  AST_SP_FALL: assert property
    ($fell(signal_present_o) |-> !$past(detect_input_pin_i, 3))
    else $error("signal present fell with detect");
  AST_LPBK_WRITE: assert property
    ($changed(scrambler_loopback_bit_o) |-> $rose(s_axi_bvalid))
    else $error("loopback changed without write");
  AST_RD_ANSWER: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_B_HOLD: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  AST_STATUS_DET: assert property
    ((!detect_input_pin_i) [*4] ##0
     (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40)
     |=> s_axi_rdata[STAT_DET_BIT])
    else $error("status detect bit not inverted");
  // main scenarios reached
  cover property ($rose(signal_present_o));
  cover property ($fell(signal_present_o));
  cover property ($rose(transmitter_off_output_o));
endmodule

bind scd_top scd_top_chk u_chk (.sys_clk_i, .rst_n_i, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .scramble_strap_pin_i,
  .detect_input_pin_i, .tx_quiet_i, .scrambler_en_o,
  .scrambler_loopback_bit_o, .signal_present_o,
  .transmitter_off_output_o);

/* pkg/scd_pkg.sv */
// constants, field layout and state codes of the scrambler detect control
// assumes a 100 MHz system clock and word-indexed register offsets
//
// Summary of operation
// - control register at index 0x0A, read/write
// - reset clears control bits 15 to 1
// - reset leaves enable bit following the strap
// - bits 13-12 pick signal-present off delay
// - bits 11-10 pick signal-present on delay
// - bits 9-8 pick transmitter-off delay or never
// - transmitter-off delay counts from scrambled quiet start
// - bit 7 delays signal-present assertion when scrambling
// - bit 6 delays signal-present deassertion when scrambling
// - bit 1 loops scrambler output into descrambler
// - strap low lets bit 0 enable scrambling
// - strap high forces enable bit to one
// - read-only line-state status at index 0x10
// - status bit 10 reads inverted detect input
package scd_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  CTRL_IDX      = 8'h0A;
  localparam logic [7:0]  STAT_IDX      = 8'h10;
  localparam logic [7:0]  IRQ_STAT_IDX  = 8'h11;
  localparam logic [7:0]  IRQ_MASK_IDX  = 8'h12;

  // control register fields
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_LPBK_BIT = 1;
  localparam int          CTRL_OFFEN_BIT = 6;
  localparam int          CTRL_ONEN_BIT = 7;
  localparam int          CTRL_OPT_LSB  = 8;
  localparam int          CTRL_ON_LSB   = 10;
  localparam int          CTRL_OFF_LSB  = 12;
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [15:0] CTRL_WMASK    = 16'hFFC3;

  // status register fields
  localparam int          STAT_DET_BIT  = 10;

  // interrupt status bits
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_RISE      = 0;
  localparam int          IRQ_FALL      = 1;
  localparam int          IRQ_TXOFF     = 2;

  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // clock and delay times
  localparam int          CLK_NS        = 10;
  localparam int          OFF0_NS       = 760;
  localparam int          OFF1_NS       = 1320;
  localparam int          OFF2_NS       = 2520;
  localparam int          OFF3_NS       = 5120;
  localparam int          ON0_NS        = 840;
  localparam int          ON1_NS        = 1320;
  localparam int          ON2_NS        = 2520;
  localparam int          ON3_NS        = 5120;
  localparam int          TXOFF30_US    = 30;
  localparam int          TXOFF50_US    = 50;

  // least delays rounded up to whole cycles
  localparam int OFF0_CYC = (OFF0_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF1_CYC = (OFF1_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF2_CYC = (OFF2_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF3_CYC = (OFF3_NS + CLK_NS - 1) / CLK_NS;
  localparam int ON0_CYC  = (ON0_NS + CLK_NS - 1) / CLK_NS;
  localparam int ON1_CYC  = (ON1_NS + CLK_NS - 1) / CLK_NS;
  localparam int ON2_CYC  = (ON2_NS + CLK_NS - 1) / CLK_NS;
  localparam int ON3_CYC  = (ON3_NS + CLK_NS - 1) / CLK_NS;
  localparam int TXOFF30_CYC = (TXOFF30_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TXOFF50_CYC = (TXOFF50_US * 1000 + CLK_NS - 1) / CLK_NS;

  // signal-present filter states
  typedef enum logic [3:0]
  {
    SD_LOW      = 4'h1,
    SD_WAIT_ON  = 4'h2,
    SD_HIGH     = 4'h4,
    SD_WAIT_OFF = 4'h8
  } scd_sd_state_t;

  // transmitter-off sequencer states
  typedef enum logic [2:0]
  {
    TX_IDLE = 3'h1,
    TX_WAIT = 3'h2,
    TX_OFF  = 3'h4
  } scd_tx_state_t;

endpackage

/* verilog/scd_sync2.sv */
// two-flop synchroniser for asynchronous pin levels
// assumes the inputs are slow levels, not single-cycle pulses
module scd_sync2
  import scd_pkg::*;
#(
  parameter int W = 2
)
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;  // first stage, read only by second stage
  logic [W-1:0] sync_q;  // second stage

  // two stages back to back
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

/* verilog/scd_timer.sv */
// loadable down-counter giving a done pulse a set number of cycles
// after start; dropping run abandons the count
// assumes load_i is at least one
module scd_timer
  import scd_pkg::*;
#(
  parameter int CNT_W = 13
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire logic             run_i,
  input  wire logic [CNT_W-1:0] load_i,
  output logic                  done_o
);

  logic [CNT_W-1:0] cnt_q;   // cycles left minus one
  logic [CNT_W-1:0] cnt_d;
  logic             busy_q;  // count in progress
  logic             busy_d;

  // done when the last cycle of the count is reached
  assign done_o = busy_q & run_i & ~start_i & (cnt_q == '0);

  // next count
  always_comb
  begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    if (start_i)
    begin
      cnt_d  = load_i - CNT_W'(1);
      busy_d = 1'b1;
    end
    else if (!run_i || done_o)
    begin
      busy_d = 1'b0;
    end
    else if (busy_q)
    begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  // count registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule

/* verilog/scd_top.sv */
// scrambler control, signal-present filter and transmitter-off timing
// with an AXI4-Lite register slave
// assumes pins are asynchronous; tx_quiet_i and lsm_info_i are on sys_clk_i
module scd_top
  import scd_pkg::*;
#(
  parameter int         CNT_W       = 13,
  parameter int         TX30_CYC    = TXOFF30_CYC,
  parameter int         TX50_CYC    = TXOFF50_CYC,
  parameter logic [4:0] REV_ID      = 5'h05  // arbitrary revision value
)
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // line side and internal datapath
  input  wire logic        scramble_strap_pin_i,
  input  wire logic        detect_input_pin_i,
  input  wire logic        tx_quiet_i,
  input  wire logic [9:0]  lsm_info_i,
  output logic             scrambler_en_o,
  output logic             scrambler_loopback_bit_o,
  output logic             signal_present_o,
  output logic             transmitter_off_output_o,
  output logic             irq_o
);

  // one-hot decode of a byte address: {mask, irq, status, control}
  function automatic logic [3:0] addr_dec(input logic [7:0] addr);
    addr_dec    = 4'h0;
    addr_dec[0] = (addr[7:2] == CTRL_IDX[5:0]);
    addr_dec[1] = (addr[7:2] == STAT_IDX[5:0]);
    addr_dec[2] = (addr[7:2] == IRQ_STAT_IDX[5:0]);
    addr_dec[3] = (addr[7:2] == IRQ_MASK_IDX[5:0]);
  endfunction

  // byte-lane merge of write data into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    merge16 = old;
    if (strb[0])
      merge16[7:0] = wd[7:0];
    if (strb[1])
      merge16[15:8] = wd[15:8];
  endfunction

  // synchronised pins
  logic [1:0]       pins_s;
  logic             strap_s;      // strap level
  logic             detect_s;     // detect level

  // bus state
  logic             aw_held_q, aw_held_d;
  logic [7:0]       aw_addr_q, aw_addr_d;
  logic             w_held_q, w_held_d;
  logic [31:0]      w_data_q, w_data_d;
  logic [3:0]       w_strb_q, w_strb_d;
  logic             bvalid_q, bvalid_d;
  logic [1:0]       bresp_q, bresp_d;
  logic             rvalid_q, rvalid_d;
  logic [31:0]      rdata_q, rdata_d;
  logic [1:0]       rresp_q, rresp_d;
  logic             do_wr;        // both write halves present
  logic [3:0]       wr_sel;       // decoded write target
  logic             ar_hs;        // read address taken
  logic [3:0]       rd_sel;       // decoded read target

  // register state
  logic [15:0]      ctrl_q, ctrl_d;
  logic [IRQ_W-1:0] irq_q, irq_d;
  logic [IRQ_W-1:0] mask_q, mask_d;
  logic [15:0]      mask_wr;      // merged mask write
  logic             irq_out_q, irq_out_d;
  logic [IRQ_W-1:0] events;
  logic [15:0]      status;
  logic             scr_en;       // scrambling active by pin or bit

  // filter and sequencer state
  scd_sd_state_t    sd_q, sd_d;
  logic             sp_q, sp_d;
  logic             sd_start;
  logic [CNT_W-1:0] sd_load;
  logic             sd_done;
  scd_tx_state_t    tx_q, tx_d;
  logic             txoff_q, txoff_d;
  logic             tx_start;
  logic [CNT_W-1:0] tx_load;
  logic             tx_done;

  // pin synchroniser
  scd_sync2 #(
    .W (2)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({scramble_strap_pin_i, detect_input_pin_i}),
    .sync_o    (pins_s)
  );

  assign strap_s  = pins_s[1];
  assign detect_s = pins_s[0];

  // bus handshakes
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign do_wr  = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_sel = addr_dec(aw_addr_q);
  assign ar_hs  = s_axi_arvalid & ~rvalid_q;
  assign rd_sel = addr_dec(s_axi_araddr);

  // read-only line-state status view
  assign status = {REV_ID, ~detect_s, lsm_info_i};

  // write channel collection and response
  always_comb
  begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (do_wr)
    begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      // status writes are ignored; unmapped addresses fail
      bresp_d   = (wr_sel != 4'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
  end

  // read channel
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_hs)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (1'b1)
        rd_sel[0]: rdata_d = {16'h0000, ctrl_q};
        rd_sel[1]: rdata_d = {16'h0000, status};
        rd_sel[2]: rdata_d = {29'h00000000, irq_q};
        rd_sel[3]: rdata_d = {29'h00000000, mask_q};
        default:
        begin
          // unmapped address
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  // bus registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // control, mask and interrupt status next values
  always_comb
  begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    mask_wr = merge16({13'h0000, mask_q}, w_data_q, w_strb_q);
    if (do_wr && wr_sel[0])
      ctrl_d = merge16(ctrl_q, w_data_q, w_strb_q);
    if (do_wr && wr_sel[3])
      mask_d = mask_wr[IRQ_W-1:0];
    // reserved bits 5-2 never store
    ctrl_d = ctrl_d & CTRL_WMASK;
    // strap high pins the enable bit to one, also right after reset
    if (strap_s)
      ctrl_d[CTRL_EN_BIT] = 1'b1;
    // a read clears, a new event in the same cycle survives
    irq_d     = ((ar_hs && rd_sel[2]) ? '0 : irq_q) | events;
    irq_out_d = |(irq_d & mask_d);
  end

  // register file
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q    <= CTRL_RST;
      mask_q    <= '0;
      irq_q     <= '0;
      irq_out_q <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      mask_q    <= mask_d;
      irq_q     <= irq_d;
      irq_out_q <= irq_out_d;
    end
  end

  // scrambling runs on either source
  assign scr_en = ctrl_q[CTRL_EN_BIT] | strap_s;
  assign scrambler_en_o           = scr_en;
  assign scrambler_loopback_bit_o = ctrl_q[CTRL_LPBK_BIT];
  assign irq_o                    = irq_out_q;

  // events for the interrupt status
  assign events[IRQ_RISE]  = sp_d & ~sp_q;
  assign events[IRQ_FALL]  = ~sp_d & sp_q;
  assign events[IRQ_TXOFF] = txoff_d & ~txoff_q;

  // delay counts for the current filter direction
  always_comb
  begin
    sd_load = CNT_W'(OFF0_CYC);
    if (sd_q == SD_LOW)
    begin
      unique case (ctrl_q[CTRL_ON_LSB +: 2])
        2'h0: sd_load = CNT_W'(ON0_CYC);
        2'h1: sd_load = CNT_W'(ON1_CYC);
        2'h2: sd_load = CNT_W'(ON2_CYC);
        2'h3: sd_load = CNT_W'(ON3_CYC);
      endcase
    end
    else
    begin
      unique case (ctrl_q[CTRL_OFF_LSB +: 2])
        2'h0: sd_load = CNT_W'(OFF0_CYC);
        2'h1: sd_load = CNT_W'(OFF1_CYC);
        2'h2: sd_load = CNT_W'(OFF2_CYC);
        2'h3: sd_load = CNT_W'(OFF3_CYC);
      endcase
    end
  end

  // signal-present filter next state
  always_comb
  begin
    sd_d     = sd_q;
    sd_start = 1'b0;
    if (!scr_en)
    begin
      // plain follow of the detect level
      sd_d = detect_s ? SD_HIGH : SD_LOW;
    end
    else
    begin
      unique case (sd_q)
        SD_LOW:
        begin
          if (detect_s && ctrl_q[CTRL_ONEN_BIT])
          begin
            sd_d     = SD_WAIT_ON;
            sd_start = 1'b1;
          end
          else if (detect_s)
            sd_d = SD_HIGH;
        end
        SD_WAIT_ON:
        begin
          // descrambler gets time to lock; a drop restarts
          if (!detect_s)
            sd_d = SD_LOW;
          else if (sd_done)
            sd_d = SD_HIGH;
        end
        SD_HIGH:
        begin
          if (!detect_s && ctrl_q[CTRL_OFFEN_BIT])
          begin
            sd_d     = SD_WAIT_OFF;
            sd_start = 1'b1;
          end
          else if (!detect_s)
            sd_d = SD_LOW;
        end
        SD_WAIT_OFF:
        begin
          // detect returning cancels the pending drop
          if (detect_s)
            sd_d = SD_HIGH;
          else if (sd_done)
            sd_d = SD_LOW;
        end
        default: sd_d = SD_LOW;
      endcase
    end
    sp_d = (sd_d == SD_HIGH) || (sd_d == SD_WAIT_OFF);
  end

  // filter registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sd_q <= SD_LOW;
      sp_q <= 1'b0;
    end
    else
    begin
      sd_q <= sd_d;
      sp_q <= sp_d;
    end
  end

  assign signal_present_o = sp_q;

  // filter delay counter
  scd_timer #(
    .CNT_W (CNT_W)
  ) u_sd_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (sd_start),
    .run_i     ((sd_q == SD_WAIT_ON) || (sd_q == SD_WAIT_OFF) || sd_start),
    .load_i    (sd_load),
    .done_o    (sd_done)
  );

  // transmitter-off sequencer next state
  always_comb
  begin
    tx_d     = tx_q;
    tx_start = 1'b0;
    tx_load  = (ctrl_q[CTRL_OPT_LSB +: 2] == 2'h1) ? CNT_W'(TX30_CYC)
                                                    : CNT_W'(TX50_CYC);
    if (!scr_en || !tx_quiet_i)
    begin
      tx_d = TX_IDLE;
    end
    else
    begin
      unique case (tx_q)
        TX_IDLE:
        begin
          // quiet symbols just started
          unique case (ctrl_q[CTRL_OPT_LSB +: 2])
            2'h0: tx_d = TX_OFF;
            2'h1, 2'h2:
            begin
              tx_d     = TX_WAIT;
              tx_start = 1'b1;
            end
            2'h3: tx_d = TX_WAIT;  // parks without arming the timer
          endcase
        end
        TX_WAIT:
        begin
          if (tx_done)
            tx_d = TX_OFF;
        end
        TX_OFF:  tx_d = TX_OFF;
        default: tx_d = TX_IDLE;
      endcase
    end
    txoff_d = (tx_d == TX_OFF);
  end

  // sequencer registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_q    <= TX_IDLE;
      txoff_q <= 1'b0;
    end
    else
    begin
      tx_q    <= tx_d;
      txoff_q <= txoff_d;
    end
  end

  assign transmitter_off_output_o = txoff_q;

  // transmitter-off delay counter
  scd_timer #(
    .CNT_W (CNT_W)
  ) u_tx_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (tx_start),
    .run_i     ((tx_q == TX_WAIT) || tx_start),
    .load_i    (tx_load),
    .done_o    (tx_done)
  );

endmodule
